// File: design/pabx_regs.svh
// register offsets, field positions and reset values of the port mux
`ifndef PABX_REGS_SVH
`define PABX_REGS_SVH

// register offsets (5-bit register address)
`define PABX_OFS_PA_DIR   5'h00
`define PABX_OFS_PB_DIR   5'h01
`define PABX_OFS_PX_DIR   5'h02
`define PABX_OFS_PX_FN    5'h03
`define PABX_OFS_MM       5'h04
`define PABX_OFS_PA_DAT   5'h05
`define PABX_OFS_PB_DAT   5'h06
`define PABX_OFS_PX_DAT   5'h07
`define PABX_OFS_STATUS   5'h08
// address bit 4 set: single-bit direction access, bit 3 picks the port
`define PABX_BIT_ACCESS   4
`define PABX_BIT_PORT     3

// reset values
`define PABX_DIR_RST      8'hFF
`define PABX_DAT_RST      8'h00
`define PABX_MM_RST       4'h0
`define PABX_MM_EXPAND    4'hE
`define PABX_PXFN_SC0     8'h00
`define PABX_PXFN_EXPAND  8'hE0

// fixed bits of the port x registers
`define PABX_PXDIR_FIXED  8'h1F
`define PABX_PX_USED      8'hE0

// positions inside the 3-pin port x group (pins 5, 6, 7)
`define PABX_PX_REFRESH   0
`define PABX_PX_WAIT      1
`define PABX_PX_CLOCK     2

// position of the address-enable bit of port a in the expansion field
`define PABX_MM_PA_EN     2

`endif

// File: design/pabx_pkg.sv
// types shared by the port a/b/x pin mux
package pabx_pkg;

    // operating-mode pin codes
    typedef enum logic [3:0] {
        pabx_mode_romless0 = 4'h0,
        pabx_mode_romless1 = 4'h1,
        pabx_mode_single0  = 4'h2,
        pabx_mode_single1  = 4'h3
    } pabx_opmode_t;

    // register port request
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pabx_bus_req_t;

    // drive side of an 8-pin port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe_n;
    } pabx_pin8_t;

    // drive side of the 3-pin port x
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe_n;
    } pabx_pin3_t;

    // whole state of the block
    typedef struct packed {
        logic       init;
        logic [3:0] mm;
        logic [7:0] pa_dir;
        logic [7:0] pb_dir;
        logic [7:0] px_dir;
        logic [7:0] px_fn;
        logic [7:0] pa_dat;
        logic [7:0] pb_dat;
        logic [7:0] px_dat;
        logic [7:0] rdata;
    } pabx_state_t;

endpackage : pabx_pkg

// File: design/pabx_top.sv
// pin function mux for address ports a and b and control port x
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "pabx_regs.svh"
//
// Notes on behaviour
// R1: port a direction from register, function from mode
// R2: a and b directions take byte and bit access
// R3: field 000 ports; field bit2 gives A0-A7
// R4: port b: 001 four, 010 six, else eight
// R5: romless or single-chip 1 reset field to 111x
// R6: writing 000x returns pins to port mode; 0001 keeps port b pins 3..0 on address
// R7: field 100x or 010x stops port b address
// R8: port x is bits 7..5, rest undefined
// R9: after such resets port x in control function
// R10: bit5 refresh out, bit6 wait in, bit7 clock
// R11: port x direction and function separate registers
// R12: port x direction write-only, low bits one
// R13: direction zero drives output, one is input
// R14: master changes port x direction bytewise only
// R15: wait pin held high while in port mode
// R16: port b direction from register, function from mode
// R17: function bits one select control, reset E0/00
// R18: function register write-only, low bits zero
// R19: port mode drives latch; control ignores direction
//
module pabx_top (
    input  wire logic                   sys_clk,     // 200 MHz clock
    input  wire logic                   rst,         // async reset
    input  wire pabx_pkg::pabx_bus_req_t bus_i,      // register request
    output logic [7:0]                  rd_data,     // read data
    input  wire logic [3:0]             mode_pins,   // operating mode
    input  wire logic [15:0]            ext_addr,    // bus address
    input  wire logic                   refresh_req, // refresh request
    input  wire logic                   clk_out_src, // clock to emit
    output logic                        wait_out,    // wait to bus
    input  wire logic [7:0]             pa_in,       // port a levels
    output pabx_pkg::pabx_pin8_t        pa_o,        // port a drive
    input  wire logic [7:0]             pb_in,       // port b levels
    output pabx_pkg::pabx_pin8_t        pb_o,        // port b drive
    input  wire logic [2:0]             px_in,       // port x levels
    output pabx_pkg::pabx_pin3_t        px_o         // port x drive
);

    ////////////////////////////////////////////////////////////////////
    // functions

    // modes whose reset leaves external expansion on
    function automatic logic pabx_expand_reset(input logic [3:0] m);
        logic r;
        r = 1'b0;
        unique case (pabx_pkg::pabx_opmode_t'(m))
            pabx_pkg::pabx_mode_romless0: r = 1'b1;
            pabx_pkg::pabx_mode_romless1: r = 1'b1;
            pabx_pkg::pabx_mode_single1:  r = 1'b1;
            pabx_pkg::pabx_mode_single0:  r = 1'b0;
            default:                      r = 1'b0;
        endcase
        return r;
    endfunction : pabx_expand_reset

    // port b pins that carry address bits
    function automatic logic [7:0] pabx_pb_mask(input logic [3:0] mm);
        logic [7:0] m;
        m = 8'h00;
        if (mm[3:1] == 3'h4 || mm[3:1] == 3'h2) begin
            m = 8'h00;                                       // R7
        end else begin
            unique case (mm[2:0])                            // R4
                3'h0:    m = 8'h00;
                3'h1:    m = 8'h0F;
                3'h2:    m = 8'h3F;
                default: m = 8'hFF;
            endcase
        end
        return m;
    endfunction : pabx_pb_mask

    // read of a port: input pins show the pin, output pins the latch
    function automatic logic [7:0] pabx_port_read(
        input logic [7:0] pin,
        input logic [7:0] dat,
        input logic [7:0] dir
    );
        return (pin & dir) | (dat & ~dir);
    endfunction : pabx_port_read

    ////////////////////////////////////////////////////////////////////
    // state

    pabx_pkg::pabx_state_t state_q;
    pabx_pkg::pabx_state_t state_d;
    logic                  pa_en;
    logic [7:0]            pb_mask;
    logic [2:0]            px_ctrl;
    logic [2:0]            px_ctrl_out;
    logic [7:0]            px_full_in;
    logic [2:0]            bit_idx;

    assign pa_en      = state_q.mm[`PABX_MM_PA_EN];                 // R3
    assign pb_mask    = pabx_pb_mask(state_q.mm);                   // R16
    assign px_ctrl    = state_q.px_fn[7:5];                         // R11
    assign px_full_in = {px_in, 5'h00};                             // R8
    assign bit_idx    = bus_i.addr[2:0];

    ////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        state_d       = state_q;
        state_d.rdata = 8'h00;
        // first cycle after reset: catch the operating mode
        if (!state_q.init) begin
            state_d.init = 1'b1;
            if (pabx_expand_reset(mode_pins)) begin
                state_d.mm    = `PABX_MM_EXPAND;                    // R5
                state_d.px_fn = `PABX_PXFN_EXPAND;                  // R9
            end else begin
                state_d.mm    = `PABX_MM_RST;
                state_d.px_fn = `PABX_PXFN_SC0;                     // R17
            end
        end
        if (bus_i.wr) begin
            if (bus_i.addr[`PABX_BIT_ACCESS]) begin
                if (bus_i.addr[`PABX_BIT_PORT]) begin
                    state_d.pb_dir[bit_idx] = bus_i.wdata[0];       // R2
                end else begin
                    state_d.pa_dir[bit_idx] = bus_i.wdata[0];       // R2
                end
            end else begin
                unique case (bus_i.addr)
                    `PABX_OFS_PA_DIR: state_d.pa_dir = bus_i.wdata; // R1
                    `PABX_OFS_PB_DIR: state_d.pb_dir = bus_i.wdata; // R16
                    `PABX_OFS_PX_DIR:
                        state_d.px_dir = bus_i.wdata
                                       | `PABX_PXDIR_FIXED;         // R12
                    `PABX_OFS_PX_FN:
                        state_d.px_fn = bus_i.wdata
                                      & `PABX_PX_USED;              // R18
                    `PABX_OFS_MM:     state_d.mm = bus_i.wdata[3:0]; // R6
                    `PABX_OFS_PA_DAT: state_d.pa_dat = bus_i.wdata;
                    `PABX_OFS_PB_DAT: state_d.pb_dat = bus_i.wdata;
                    `PABX_OFS_PX_DAT:
                        state_d.px_dat = bus_i.wdata & `PABX_PX_USED;
                    default: ;
                endcase
            end
        end
        if (bus_i.rd) begin
            if (bus_i.addr[`PABX_BIT_ACCESS]) begin
                if (bus_i.addr[`PABX_BIT_PORT]) begin
                    state_d.rdata = {7'h00, state_q.pb_dir[bit_idx]}; // R2
                end else begin
                    state_d.rdata = {7'h00, state_q.pa_dir[bit_idx]}; // R2
                end
            end else begin
                unique case (bus_i.addr)
                    `PABX_OFS_PA_DIR: state_d.rdata = state_q.pa_dir;
                    `PABX_OFS_PB_DIR: state_d.rdata = state_q.pb_dir;
                    `PABX_OFS_MM:     state_d.rdata = {4'h0, state_q.mm};
                    `PABX_OFS_PA_DAT:
                        state_d.rdata = pabx_port_read(pa_in,
                            state_q.pa_dat, state_q.pa_dir);
                    `PABX_OFS_PB_DAT:
                        state_d.rdata = pabx_port_read(pb_in,
                            state_q.pb_dat, state_q.pb_dir);
                    `PABX_OFS_PX_DAT:
                        state_d.rdata = pabx_port_read(px_full_in,
                            state_q.px_dat, state_q.px_dir)
                            & `PABX_PX_USED;                        // R8
                    `PABX_OFS_STATUS:
                        state_d.rdata = {state_q.init, pa_en,
                                         |pb_mask, 1'b0, mode_pins};
                    // write-only and unmapped registers read as zero
                    default: state_d.rdata = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_q <= '{init:   1'b0,
                         mm:     `PABX_MM_RST,
                         pa_dir: `PABX_DIR_RST,
                         pb_dir: `PABX_DIR_RST,
                         px_dir: `PABX_DIR_RST,
                         px_fn:  `PABX_PXFN_SC0,
                         pa_dat: `PABX_DAT_RST,
                         pb_dat: `PABX_DAT_RST,
                         px_dat: `PABX_DAT_RST,
                         rdata:  8'h00};
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin drive

    assign rd_data = state_q.rdata;

    // port a: whole port is address or port
    always_comb begin
        if (pa_en) begin
            pa_o.out  = ext_addr[7:0];                              // R3
            pa_o.oe_n = 8'h00;
        end else begin
            pa_o.out  = state_q.pa_dat;                             // R19
            pa_o.oe_n = state_q.pa_dir;                             // R13
        end
    end

    // port b: mask picks the address pins
    assign pb_o.out  = (ext_addr[15:8] & pb_mask)
                     | (state_q.pb_dat & ~pb_mask);                 // R4
    assign pb_o.oe_n = state_q.pb_dir & ~pb_mask;                   // R16

    // port x: control function overrides direction
    assign px_ctrl_out[`PABX_PX_REFRESH] = refresh_req;             // R10
    assign px_ctrl_out[`PABX_PX_WAIT]    = 1'b0;
    assign px_ctrl_out[`PABX_PX_CLOCK]   = clk_out_src;             // R10

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            if (px_ctrl[i]) begin
                px_o.out[i]  = px_ctrl_out[i];                      // R19
                px_o.oe_n[i] = (i == `PABX_PX_WAIT);                // R10
            end else begin
                px_o.out[i]  = state_q.px_dat[i + 5];               // R19
                px_o.oe_n[i] = state_q.px_dir[i + 5];               // R13
            end
        end
    end

    // wait is inactive high while the pin is a port
    assign wait_out = px_ctrl[`PABX_PX_WAIT] ? px_in[`PABX_PX_WAIT]
                                             : 1'b1;                // R10

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_reset_release;
        !state_q.init ##1 state_q.init;
    endsequence

    sequence s_wr(logic [4:0] a);
        bus_i.wr && bus_i.addr == a;
    endsequence

    a_mode_catch_field: assert property (                           // R5
        s_reset_release |->
            state_q.mm == (pabx_expand_reset($past(mode_pins, 1))
                           ? `PABX_MM_EXPAND : `PABX_MM_RST)
    ) else $error("expansion field wrong after reset");

    a_mode_catch_fn: assert property (                              // R17
        s_reset_release |->
            state_q.px_fn == (pabx_expand_reset($past(mode_pins, 1))
                              ? `PABX_PXFN_EXPAND : `PABX_PXFN_SC0)
    ) else $error("function select wrong after reset");

    a_pxdir_write: assert property (                                // R12
        s_wr(`PABX_OFS_PX_DIR) |=>
            state_q.px_dir == ($past(bus_i.wdata) | `PABX_PXDIR_FIXED)
    ) else $error("port x direction write wrong");

    a_pxfn_write: assert property (                                 // R18
        s_wr(`PABX_OFS_PX_FN) |=>
            state_q.px_fn == ($past(bus_i.wdata) & `PABX_PX_USED)
    ) else $error("port x function write wrong");

    a_bit_write_a: assert property (                                // R2
        bus_i.wr && bus_i.addr[4:3] == 2'h2 |=>
            state_q.pa_dir[$past(bus_i.addr[2:0])] == $past(bus_i.wdata[0])
    ) else $error("port a bit write lost");

    a_pa_address: assert property (                                 // R3
        state_q.mm[2] |-> pa_o.oe_n == 8'h00 && pa_o.out == ext_addr[7:0]
    ) else $error("port a not carrying address");

    a_pb_four: assert property (                                    // R4
        state_q.mm == 4'h1 |->
            pb_o.oe_n[3:0] == 4'h0 && pb_o.out[3:0] == ext_addr[11:8]
            && pb_o.oe_n[7:4] == state_q.pb_dir[7:4]
    ) else $error("port b lower four not address");

    a_pb_disable: assert property (                                 // R7
        state_q.mm[3:1] == 3'h4 || state_q.mm[3:1] == 3'h2 |->
            pb_o.oe_n == state_q.pb_dir && pb_o.out == state_q.pb_dat
    ) else $error("port b address not disabled");

    a_px_clock: assert property (                                   // R10
        state_q.px_fn[7] |-> !px_o.oe_n[2] && px_o.out[2] == clk_out_src
    ) else $error("clock output not driven");

    a_px_port_drive: assert property (                              // R19
        !state_q.px_fn[5] && !state_q.px_dir[5] |->
            !px_o.oe_n[0] && px_o.out[0] == state_q.px_dat[5]
    ) else $error("port x latch not driven");

    a_mm_read: assert property (                                    // R1
        bus_i.rd && bus_i.addr == `PABX_OFS_MM ##1 !bus_i.wr[*1] |->
            rd_data == {4'h0, state_q.mm}
    ) else $error("field read back wrong");

    a_pb_six: assert property (                                     // R4
        state_q.mm == 4'h2 |->
            pb_o.oe_n[5:0] == 6'h00 && pb_o.out[5:0] == ext_addr[13:8]
            && pb_o.oe_n[7:6] == state_q.pb_dir[7:6]
    ) else $error("port b lower six not address");

    a_pb_eight: assert property (                                   // R4
        state_q.mm[2:0] == 3'h3 || state_q.mm == 4'hE |->
            pb_o.oe_n == 8'h00 && pb_o.out == ext_addr[15:8]
    ) else $error("port b not carrying all address");

    a_pa_port_mode: assert property (                               // R1
        !state_q.mm[2] |->
            pa_o.oe_n == state_q.pa_dir && pa_o.out == state_q.pa_dat
    ) else $error("port a not in port mode");

    a_px_refresh: assert property (                                 // R10
        state_q.px_fn[5] |-> !px_o.oe_n[0] && px_o.out[0] == refresh_req
    ) else $error("refresh request not driven");

    a_px_wait_in: assert property (                                 // R10
        state_q.px_fn[6] |-> px_o.oe_n[1] && wait_out == px_in[1]
    ) else $error("wait pin not an input");

    a_px_wait_idle: assert property (                               // R10
        !state_q.px_fn[6] |-> wait_out
    ) else $error("wait active in port mode");

    a_pxdir_fixed: assert property (                                // R12
        state_q.px_dir[4:0] == 5'h1F
    ) else $error("port x direction low bits lost");

    a_pxfn_fixed: assert property (                                 // R18
        state_q.px_fn[4:0] == 5'h00
    ) else $error("port x function low bits set");

    a_bit_write_b: assert property (                                // R2
        bus_i.wr && bus_i.addr[4:3] == 2'h3 |=>
            state_q.pb_dir[$past(bus_i.addr[2:0])] == $past(bus_i.wdata[0])
    ) else $error("port b bit write lost");

    a_rd_idle: assert property (                                    // R2
        !bus_i.rd |=> rd_data == 8'h00
    ) else $error("read data stands too long");

endmodule : pabx_top

// File: verification/pabx_ext_model.sv
// external memory side of the port a/b/x pins
`timescale 1ns/100ps
module pabx_ext_model (
    input  wire pabx_pkg::pabx_pin8_t pa_o,     // port a drive
    input  wire pabx_pkg::pabx_pin8_t pb_o,     // port b drive
    input  wire pabx_pkg::pabx_pin3_t px_o,     // port x drive
    input  wire logic                 wait_low, // request a wait
    output logic [7:0]                pa_in,    // port a levels
    output logic [7:0]                pb_in,    // port b levels
    output logic [2:0]                px_in     // port x levels
);
    // released lines sit on their pull-ups
    assign pa_in    = pa_o.out | pa_o.oe_n;
    assign pb_in    = pb_o.out | pb_o.oe_n;
    assign px_in[0] = px_o.out[0] | px_o.oe_n[0];
    assign px_in[2] = px_o.out[2] | px_o.oe_n[2];
    // wait line held high unless a wait is asked for or the chip drives it
    assign px_in[1] = px_o.oe_n[1] ? ~wait_low : px_o.out[1];
endmodule : pabx_ext_model

// File: verification/pabx_top_test.sv
// register and pin checks of the port a/b/x mux
`timescale 1ns/100ps
`include "pabx_regs.svh"
module pabx_top_test;
    logic                    sys_clk;
    logic                    rst;
    pabx_pkg::pabx_bus_req_t bus;
    logic [7:0]              rd_data;
    logic [3:0]              mode_pins;
    logic [15:0]             ext_addr;
    logic                    refresh_req;
    logic                    clk_out_src;
    logic                    wait_out;
    logic                    wait_low;
    logic [7:0]              pa_in;
    logic [7:0]              pb_in;
    logic [2:0]              px_in;
    pabx_pkg::pabx_pin8_t    pa_o;
    pabx_pkg::pabx_pin8_t    pb_o;
    pabx_pkg::pabx_pin3_t    px_o;
    int                      errors;
    int                      n_tests;
    int                      cycles;
    logic [7:0]              rv;
    logic [7:0]              am;
    logic [7:0]              bm;
    logic                    ctl;
    logic [3:0]              md;

    pabx_top i_dut (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .bus_i       (bus),
        .rd_data     (rd_data),
        .mode_pins   (mode_pins),
        .ext_addr    (ext_addr),
        .refresh_req (refresh_req),
        .clk_out_src (clk_out_src),
        .wait_out    (wait_out),
        .pa_in       (pa_in),
        .pa_o        (pa_o),
        .pb_in       (pb_in),
        .pb_o        (pb_o),
        .px_in       (px_in),
        .px_o        (px_o)
    );

    pabx_ext_model i_ext (
        .pa_o     (pa_o),
        .pb_o     (pb_o),
        .px_o     (px_o),
        .wait_low (wait_low),
        .pa_in    (pa_in),
        .pb_in    (pb_in),
        .px_in    (px_in)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("errors %0d checks %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge sys_clk);
        bus.wr    <= 1'b0;
        #1;
    endtask : bus_wr

    task automatic bus_rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge sys_clk);
        bus.rd   <= 1'b0;
        #1;
        d = rd_data;
    endtask : bus_rd

    task automatic do_reset(input logic [3:0] m);
        @(posedge sys_clk);
        rst       <= 1'b1;
        mode_pins <= m;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
    endtask : do_reset

    function automatic logic [7:0] pb_mask(input logic [3:0] m);
        if (m[3:1] == 3'b100 || m[3:1] == 3'b010) begin
            return 8'h00;
        end
        case (m[2:0])
            3'b000:  return 8'h00;
            3'b001:  return 8'h0F;
            3'b010:  return 8'h3F;
            default: return 8'hFF;
        endcase
    endfunction : pb_mask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("BAD %0t run did not finish", $time);
            report_and_stop();
        end
    end

    initial begin
        rst = 1'b1;
        bus = '0;
        mode_pins = 4'h2;
        ext_addr = 16'hB6D5;
        refresh_req = 1'b0;
        clk_out_src = 1'b1;
        wait_low = 1'b0;
        errors = 0;
        n_tests = 0;
        cycles = 0;
        for (int m = 0; m < 5; m++) begin
            md = 4'(m + 15);
            do_reset(md);
            ctl = (md == 4'h0 || md == 4'h1 || md == 4'h3);
            bus_rd(`PABX_OFS_MM, rv);
            chk(rv[3:1], ctl ? 3'b111 : 3'b000, "field at reset");
            chk(px_o.oe_n, ctl ? 3'b010 : 3'b111, "px at reset");
            chk(pa_o.oe_n, ctl ? 8'h00 : 8'hFF, "pa at reset");
            chk(pb_o.oe_n, ctl ? 8'h00 : 8'hFF, "pb at reset");
        end
        $display("test reset_modes done");
        for (int i = 0; i < 2; i++) begin
            @(posedge sys_clk);
            refresh_req <= i[0];
            clk_out_src <= ~i[0];
            wait_low    <= i[0];
            #1;
            chk({px_o.out[2], px_o.out[0]}, {~i[0], i[0]}, "ctl out");
            chk(wait_out, !i[0], "wait in");
        end
        wait_low <= 1'b0;
        $display("test control_pins done");
        bus_wr(`PABX_OFS_PA_DIR, 8'h5A);
        bus_wr(`PABX_OFS_PA_DAT, 8'hC3);
        bus_wr(`PABX_OFS_PB_DIR, 8'hA5);
        bus_wr(`PABX_OFS_PB_DAT, 8'h3C);
        for (int m = 0; m < 16; m++) begin
            bus_wr(`PABX_OFS_MM, 8'(m));
            am = m[2] ? 8'hFF : 8'h00;
            bm = pb_mask(m[3:0]);
            chk(pa_o.oe_n, ~am & 8'h5A, "pa enables");
            chk(pa_o.out & am, ext_addr[7:0] & am, "pa addr");
            chk(pa_o.out & ~am & ~8'h5A, 8'hC3 & ~am & ~8'h5A, "pa latch");
            chk(pb_o.oe_n, ~bm & 8'hA5, "pb enables");
            chk(pb_o.out & bm, ext_addr[15:8] & bm, "pb addr");
            bus_rd(`PABX_OFS_MM, rv);
            chk(rv, {4'h0, m[3:0]}, "field readback");
        end
        $display("test field_sweep done");
        bus_wr(`PABX_OFS_MM, 8'h00);
        bus_wr(`PABX_OFS_PA_DIR, 8'h00);
        bus_wr(5'h13, 8'h01);
        bus_rd(`PABX_OFS_PA_DIR, rv);
        chk(rv, 8'h08, "pa dir bit set");
        chk(pa_o.oe_n, 8'h08, "pa dir pins");
        bus_rd(5'h13, rv);
        chk(rv, 8'h01, "pa bit read");
        bus_wr(`PABX_OFS_PB_DIR, 8'hFF);
        bus_wr(5'h1F, 8'h00);
        bus_rd(`PABX_OFS_PB_DIR, rv);
        chk(rv, 8'h7F, "pb dir bit clear");
        chk(pb_o.oe_n, 8'h7F, "pb dir pins");
        bus_rd(`PABX_OFS_PA_DAT, rv);
        chk(rv, 8'hCB, "pa data read");
        bus_rd(`PABX_OFS_PB_DAT, rv);
        chk(rv, 8'h7F, "pb data read");
        bus_rd(`PABX_OFS_STATUS, rv);
        chk(rv, 8'h83, "status read");
        $display("test dir_access done");
        bus_wr(`PABX_OFS_PX_FN, 8'h00);
        chk(wait_out, 1'b1, "wait idle as port");
        bus_wr(`PABX_OFS_PX_DAT, 8'hA0);
        bus_wr(`PABX_OFS_PX_DIR, 8'h40);
        chk(px_o.oe_n, 3'b010, "px dir");
        chk(px_o.out & 3'b101, 3'b101, "px latch");
        bus_rd(`PABX_OFS_PX_DAT, rv);
        chk(rv, 8'hE0, "px data read");
        bus_rd(`PABX_OFS_PX_DIR, rv);
        chk(rv, 8'h00, "px dir write only");
        bus_wr(`PABX_OFS_PX_DIR, 8'hE0);
        chk(px_o.oe_n, 3'b111, "px all inputs");
        bus_wr(`PABX_OFS_PX_FN, 8'hFF);
        chk(px_o.oe_n, 3'b010, "ctl ignores dir");
        bus_rd(`PABX_OFS_PX_FN, rv);
        chk(rv, 8'h00, "px fn write only");
        $display("test port_x done");
        report_and_stop();
    end
endmodule : pabx_top_test
